//--- rtl/itm_consts.vh
// Constants for the instruction tight memory interface
`ifndef ITM_CONSTS_VH
`define ITM_CONSTS_VH
`define ITM_ADDR_W       18
`define ITM_DATA_W       32
`define ITM_LANES        4
`define ITM_SZ_ABSENT    4'h0
`define ITM_SZ_4K        4'h3
`define ITM_SZ_1M        4'hb
`define ITM_SZ_MIN_LOG2  5'h0c
`define ITM_LOG2_NONE    5'h00
`define ITM_SZ_BASE      4'h3
`define ITM_ACC_BYTE     2'h0
`define ITM_ACC_HALF     2'h1
`define ITM_ACC_WORD     2'h2
`define ITM_STB_NONE     4'h0
`define ITM_STB_ALL      4'hf
`define ITM_STB_HALF     4'h3
`define ITM_STB_BYTE     4'h1
`define ITM_ST_IDLE      1'b0
`define ITM_ST_WAIT      1'b1
`endif

//--- rtl/itm_tcm_if.v
// Instruction tight memory interface, processor side
`timescale 1ns/1ps
`default_nettype none
`include "itm_consts.vh"

module itm_tcm_if #(
  parameter AW = `ITM_ADDR_W,
  parameter DW = `ITM_DATA_W
) (
  // Clock and reset
  input  wire          i_sys_clk,
  input  wire          i_rst_b,
  // Core request side
  input  wire          i_req_valid,
  input  wire          i_req_write,
  input  wire [1:0]    i_req_size,
  input  wire [AW+1:0] i_req_byte_addr,
  input  wire [DW-1:0] i_req_wdata,
  output reg           o_req_ready,
  output reg           o_rdata_valid,
  output reg  [DW-1:0] o_rdata,
  // Static size configuration
  input  wire [3:0]    i_itm_size_cfg,
  output reg           o_itm_present,
  output reg  [4:0]    o_itm_size_log2,
  // DMA override
  input  wire          i_itm_dma_enable,
  input  wire [AW-1:0] i_itm_dma_addr,
  input  wire          i_itm_dma_chip_select,
  // Memory side
  input  wire [DW-1:0] i_itm_read_data,
  input  wire          i_itm_wait,
  output reg           o_itm_chip_select,
  output reg  [AW-1:0] o_itm_word_addr,
  output reg           o_itm_read_not_write,
  output reg           o_itm_sequential,
  output reg  [3:0]    o_itm_byte_strobes,
  output reg  [DW-1:0] o_itm_write_data,
  output reg           o_itm_idle
);

  // Synchronised static size input
  reg  [3:0]    size_s1_reg;
  reg  [3:0]    size_s2_reg;
  reg           present_next;
  reg  [4:0]    log2_next;

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      size_s1_reg <= `ITM_SZ_ABSENT;
      size_s2_reg <= `ITM_SZ_ABSENT;
    end else begin
      size_s1_reg <= i_itm_size_cfg;
      size_s2_reg <= size_s1_reg;
    end
  end

  always @* begin
    present_next = 1'b0;
    log2_next    = `ITM_LOG2_NONE;
    // Valid codes 4KB..1MB; reserved codes read as absent
    if (size_s2_reg >= `ITM_SZ_4K && size_s2_reg <= `ITM_SZ_1M) begin
      present_next = 1'b1;
      log2_next    = `ITM_SZ_MIN_LOG2 + {1'b0, size_s2_reg} - {1'b0, `ITM_SZ_BASE};
    end
  end

  // Request tracking state
  reg           state_reg;
  reg           state_next;
  reg  [AW-1:0] last_addr_reg;
  reg  [AW-1:0] last_addr_next;
  reg           last_valid_reg;
  reg           last_valid_next;
  reg           dma_prev_reg;

  // Next values of the registered outputs
  reg           ready_next;
  reg           rdata_valid_next;
  reg  [DW-1:0] rdata_next;
  reg           chip_select_next;
  reg  [AW-1:0] word_addr_next;
  reg           read_not_write_next;
  reg           sequential_next;
  reg  [3:0]    strobes_next;
  reg  [DW-1:0] write_data_next;
  reg           idle_next;

  // Request decode
  wire [AW-1:0] req_word   = i_req_byte_addr[AW+1:2];
  wire [AW-1:0] next_word  = last_addr_reg + {{(AW-1){1'b0}}, 1'b1};
  wire          in_req     = (state_reg == `ITM_ST_WAIT);
  wire          dma_cyc    = i_itm_dma_enable && i_itm_dma_chip_select;
  wire          accept     = i_req_valid && present_next && !in_req && !dma_cyc;
  wire          served     = in_req && !i_itm_wait;
  // No sequential claim straight after a DMA cycle
  wire          follows_on = last_valid_reg && !dma_prev_reg && (req_word == next_word);

  // Lane patterns for byte and halfword writes
  wire [3:0]    byte_lane  = `ITM_STB_BYTE << i_req_byte_addr[1:0];
  wire [3:0]    half_lane  = `ITM_STB_HALF << {i_req_byte_addr[1], 1'b0};
  wire          size_byte  = (i_req_size == `ITM_ACC_BYTE);
  wire          size_half  = (i_req_size == `ITM_ACC_HALF);
  wire [3:0]    strobe_req;
  genvar        lane;

  generate
    for (lane = 0; lane < `ITM_LANES; lane = lane + 1) begin : g_lane
      // Reads leave every lane clear
      assign strobe_req[lane] = i_req_write && (size_byte ? byte_lane[lane] :
                                                size_half ? half_lane[lane] : 1'b1);
    end
  endgenerate

  // Next-state and next-output decode
  always @* begin
    state_next          = state_reg;
    last_addr_next      = last_addr_reg;
    last_valid_next     = last_valid_reg;
    ready_next          = 1'b0;
    rdata_valid_next    = 1'b0;
    rdata_next          = o_rdata;
    chip_select_next    = accept || dma_cyc;
    word_addr_next      = o_itm_word_addr;
    read_not_write_next = o_itm_read_not_write;
    sequential_next     = o_itm_sequential;
    strobes_next        = o_itm_byte_strobes;
    write_data_next     = o_itm_write_data;
    idle_next           = o_itm_idle;
    case (state_reg)
      `ITM_ST_IDLE: begin
        if (accept) begin
          state_next          = `ITM_ST_WAIT;
          word_addr_next      = req_word;
          read_not_write_next = i_req_write;
          strobes_next        = strobe_req;
          write_data_next     = i_req_wdata;
          sequential_next     = follows_on;
          idle_next           = 1'b0;
          last_addr_next      = req_word;
          last_valid_next     = 1'b1;
        end else begin
          idle_next       = 1'b1;
          sequential_next = 1'b0;
          if (dma_cyc) begin
            word_addr_next  = i_itm_dma_addr;
            last_valid_next = 1'b0;
          end
        end
      end
      `ITM_ST_WAIT: begin
        // Request outputs other than chip select held while the memory stalls
        if (served) begin
          state_next       = `ITM_ST_IDLE;
          ready_next       = 1'b1;
          idle_next        = 1'b1;
          rdata_valid_next = !o_itm_read_not_write;
          if (!o_itm_read_not_write) begin
            rdata_next = i_itm_read_data;
          end
        end
      end
      default: begin
        state_next = `ITM_ST_IDLE;
      end
    endcase
  end

  // Access state and address history
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= `ITM_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last_addr_reg <= {AW{1'b0}};
    end else begin
      last_addr_reg <= last_addr_next;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last_valid_reg <= 1'b0;
    end else begin
      last_valid_reg <= last_valid_next;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dma_prev_reg <= 1'b0;
    end else begin
      dma_prev_reg <= dma_cyc;
    end
  end

  // Size report towards the core
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_itm_present <= 1'b0;
    end else begin
      o_itm_present <= present_next;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_itm_size_log2 <= `ITM_LOG2_NONE;
    end else begin
      o_itm_size_log2 <= log2_next;
    end
  end

  // Completion handshake towards the core
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_req_ready <= 1'b0;
    end else begin
      o_req_ready <= ready_next;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata_valid <= 1'b0;
    end else begin
      o_rdata_valid <= rdata_valid_next;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= {DW{1'b0}};
    end else begin
      o_rdata <= rdata_next;
    end
  end

  // Request cycle outputs towards the memory
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_itm_chip_select <= 1'b0;
    end else begin
      o_itm_chip_select <= chip_select_next;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_itm_word_addr <= {AW{1'b0}};
    end else begin
      o_itm_word_addr <= word_addr_next;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_itm_read_not_write <= 1'b0;
    end else begin
      o_itm_read_not_write <= read_not_write_next;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_itm_sequential <= 1'b0;
    end else begin
      o_itm_sequential <= sequential_next;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_itm_byte_strobes <= `ITM_STB_NONE;
    end else begin
      o_itm_byte_strobes <= strobes_next;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_itm_write_data <= {DW{1'b0}};
    end else begin
      o_itm_write_data <= write_data_next;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_itm_idle <= 1'b1;
    end else begin
      o_itm_idle <= idle_next;
    end
  end

endmodule // itm_tcm_if
`default_nettype wire

//--- bench/itm_tcm_if_chk.sv
// Assertion checker for the instruction memory interface
`timescale 1ns/1ps
`default_nettype none
module itm_tcm_if_chk #(parameter AW = 18, parameter DW = 32) (
  input wire logic i_sys_clk, i_rst_b, i_itm_wait, i_itm_dma_enable, i_itm_dma_chip_select, o_req_ready,
  input wire logic o_rdata_valid, o_itm_chip_select, o_itm_read_not_write, o_itm_sequential, o_itm_idle,
  input wire logic [AW-1:0] i_itm_dma_addr, o_itm_word_addr,
  input wire logic [DW-1:0] i_itm_read_data, o_rdata, o_itm_write_data,
  input wire logic [3:0] o_itm_byte_strobes);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  wire logic busy = !o_itm_idle;
  wire logic rd_take = busy && !i_itm_wait && !o_itm_read_not_write;
  sequence s_stall; busy && i_itm_wait; endsequence
  sequence s_serve; busy && !i_itm_wait; endsequence
  chk_wait_hold: assert property (s_stall |=> busy && $stable(o_itm_word_addr) && $stable(o_itm_write_data)
    && $stable(o_itm_byte_strobes) && $stable(o_itm_read_not_write) && $stable(o_itm_sequential)) else $error("moved");
  chk_serve_ready: assert property (s_serve |=> o_req_ready ##1 !o_req_ready) else $error("no ready");
  chk_idle_quiet: assert property (o_itm_idle |=> !o_req_ready && !o_rdata_valid) else $error("idle done");
  chk_rdata_take: assert property ($past(rd_take) == o_rdata_valid
    && (!o_rdata_valid || o_rdata == $past(i_itm_read_data))) else $error("bad read");
  chk_read_nostb: assert property (rd_take |-> o_itm_byte_strobes == 4'h0) else $error("read lanes");
  chk_write_stb: assert property (busy && o_itm_read_not_write |-> o_itm_byte_strobes inside
    {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf}) else $error("write lanes");
  chk_cs_start: assert property ($fell(o_itm_idle) |-> o_itm_chip_select) else $error("no select");
  chk_dma_route: assert property (i_itm_dma_enable && i_itm_dma_chip_select |=> o_itm_chip_select
    && o_itm_word_addr == $past(i_itm_dma_addr)) else $error("dma route");
endmodule // itm_tcm_if_chk
bind itm_tcm_if itm_tcm_if_chk #(.AW(AW), .DW(DW)) itm_tcm_if_chk_inst (.*);
`default_nettype wire

//--- bench/itm_mem_model.sv
// Behavioural instruction memory with optional wait states
`timescale 1ns/1ps
`default_nettype none
module itm_mem_model (
  input wire logic i_sys_clk, i_slow, i_idle, i_rnw,
  input wire logic [17:0] i_addr,
  input wire logic [3:0] i_stb,
  input wire logic [31:0] i_wd,
  output logic o_wait,
  output logic [31:0] o_rd);
  logic [31:0] mem [16];
  logic [31:0] junk = 32'h0;
  // Sequential hint never consulted
  always @(posedge i_sys_clk) begin
    junk <= ~junk;
    o_wait <= i_slow & ~o_wait;
    if (!i_idle && !o_wait && i_rnw)
      for (int b = 0; b < 4; b++) if (i_stb[b]) mem[i_addr[3:0]][8*b +: 8] <= i_wd[8*b +: 8];
  end
  assign o_rd = (!i_idle && !o_wait) ? mem[i_addr[3:0]] : junk;
endmodule // itm_mem_model
`default_nettype wire

//--- bench/test_itm_tcm_if.sv
// Self-checking bench for the instruction memory interface
`timescale 1ns/1ps
`default_nettype none
module test_itm_tcm_if;
  logic clk = 0, rst_b = 0, vld = 0, wr = 0, slow = 0, dma_en = 0, dma_cs = 0;
  logic [1:0] sz = 0; logic [19:0] ba = 0; logic [31:0] wd = 0, shadow [16]; logic [3:0] cfg = 4'hb;
  logic [17:0] dma_a = 0, prev_w = 0; logic prev_ok = 0;
  wire logic rdy, rv, pres, idle, rnw, wt, sq; wire logic [31:0] rdat, rd, wdo; wire logic [17:0] wa;
  wire logic [3:0] stb; wire logic [4:0] lg;
  int err_total = 0, comparisons = 0;
  initial forever #12.5 clk = ~clk;
  itm_tcm_if itm_tcm_if_inst (.i_sys_clk(clk), .i_rst_b(rst_b), .i_req_valid(vld), .i_req_write(wr), .i_req_size(sz),
    .i_req_byte_addr(ba), .i_req_wdata(wd), .o_req_ready(rdy), .o_rdata_valid(rv), .o_rdata(rdat), .i_itm_size_cfg(cfg),
    .o_itm_present(pres), .o_itm_size_log2(lg), .i_itm_dma_enable(dma_en), .i_itm_dma_addr(dma_a),
    .i_itm_dma_chip_select(dma_cs), .i_itm_read_data(rd), .i_itm_wait(wt), .o_itm_chip_select(), .o_itm_word_addr(wa),
    .o_itm_read_not_write(rnw), .o_itm_sequential(sq), .o_itm_byte_strobes(stb), .o_itm_write_data(wdo), .o_itm_idle(idle));
  itm_mem_model itm_mem_model_inst (.i_sys_clk(clk), .i_slow(slow), .i_idle(idle), .i_rnw(rnw), .i_addr(wa),
    .i_stb(stb), .i_wd(wdo), .o_wait(wt), .o_rd(rd));
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input [31:0] exp, got);
    comparisons++;
    if (exp !== got) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function [3:0] lanes(input [1:0] s, input [1:0] a);
    lanes = s[1] ? 4'hf : s[0] ? 4'h3 << {a[1], 1'b0} : 4'h1 << a;
  endfunction
  // Valid stays up after ready so that requests run back to back
  task acc(input w, input [1:0] s, input [19:0] a, input [31:0] d);
    int n; logic [3:0] m;
    m = lanes(s, a[1:0]);
    n = 0;
    @(negedge clk) {vld, wr, sz, ba, wd, slow} = {1'b1, w, s, a, d, 1'($urandom)};
    do begin
      @(posedge clk); #1; n++;
      if (n == 1) begin
        chk("addr", a[19:2], wa);
        chk("rnw", w, rnw);
        chk("lanes", w ? m : 4'h0, stb);
        chk("seq", prev_ok && a[19:2] == prev_w + 18'h1, sq);
        if (w) chk("wdata", d, wdo);
      end
    end while (rdy !== 1'b1 && n < 40);
    if (rdy !== 1'b1) begin err_total++; wrap_up; end
    chk("rvalid", !w, rv);
    if (w) for (int b = 0; b < 4; b++) begin if (m[b]) shadow[a[5:2]][8*b +: 8] = d[8*b +: 8]; end
    else chk("rdata", shadow[a[5:2]], rdat);
    prev_w = a[19:2];
    prev_ok = 1'b1;
  endtask
  initial begin
    void'($urandom(32'ha7c0));
    repeat (8) @(negedge clk);
    rst_b = 1;
    for (int c = 0; c < 16; c++) begin
      @(negedge clk) cfg = 4'(c);
      repeat (4) @(negedge clk);
      chk("log2", (c > 2 && c < 12) ? c + 9 : 0, lg);
      chk("present", c > 2 && c < 12, pres);
    end
    cfg = 4'hb;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 16; i++) acc(1'b1, 2'h2, 20'(i * 4), $urandom);
    for (int i = 0; i < 80; i++) acc(1'($urandom), 2'($urandom), 20'($urandom & 32'h3f), $urandom);
    @(negedge clk) {vld, dma_en, dma_cs, dma_a} = {3'b011, 18'h2a5a5};
    @(posedge clk) #1 chk("dma_addr", 18'h2a5a5, wa);
    prev_ok = 1'b0;
    @(negedge clk) {dma_en, dma_cs} = 2'b00;
    acc(1'b0, 2'h2, 20'({prev_w[3:0] + 4'h1, 2'b00}), 32'h0);
    wrap_up;
  end
endmodule // test_itm_tcm_if
`default_nettype wire
